// ### logic/tw_master.sv
/*
 * Two-wire bus interface: master transmit sequencer, slave address
 * listener with receive, and the register file on Avalon-MM.
 * Assumes open-drain pads resolved outside; clk at 10 MHz.
 */
`default_nettype none
`include "tw_cfg.svh"

// Functional notes
// - Unit reset/rate register bits 7..2 always read one, writes ignored.
// - Writing unit reset one idles the bus engine, registers keep values.
// - Rate extension bit with prescale field sets the master bit rate.
// - After master end, idle shows all status flags zero once software clears.
// - Master frame end shows master, busy and transfer end set.
// - Own address match shows slave, receive, busy and matched flag.
// - General call sets matched and general call flags, busy, slave.
// - Slave frame end leaves transfer end clear; ack bit shows value.
// - First frame after a start is exactly eight bits.
// - Start is data falling while clock stays high.
// - Stop is data rising while clock stays high.
// - Direction bit one means slave to master, zero master to slave.
// - Receiver pulls data low in the ack slot to acknowledge.
// - Busy one with qualifier zero makes start, sets interrupt and end flags.
// - First frame carries seven-bit address then direction bit.
// - Interrupt flag rises at ninth clock rise; master holds clock low until data or stop, slave never drives it.
// - Transmit loads returned ack; receive sends software ack bit.
module tw_master
    import tw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             irq
);

    tw_state_t   r;
    tw_state_t   n;
    logic        scl_s;
    logic        sda_s;
    logic        wr;
    logic        rd;
    logic [7:0]  wd;
    logic [3:0]  shift;
    logic [15:0] half_lim;
    logic        tick;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        start_req;
    logic        stop_req;
    logic [7:0]  tx_rev;

    tw_sync u_scl_sync (.clk(clk), .rst_b(rst_b), .d(scl_i), .q(scl_s));
    tw_sync u_sda_sync (.clk(clk), .rst_b(rst_b), .d(sda_i), .q(sda_s));

    // One wait cycle per access, then the access takes effect
    assign avs_waitrequest = (avs_read | avs_write) & ~r.bus_ack;
    assign wr              = avs_write & r.bus_ack & avs_byteenable[0];
    assign rd              = avs_read & r.bus_ack;
    assign wd              = avs_writedata[7:0];

    // Mirrored byte for lsb-first order, kept out of the select to stay legal
    assign tx_rev = {<<{r.tx_data}};

    assign shift    = {1'b0, r.cks} + {3'h0, ~r.rate_ext};
    assign half_lim = `TW_HALF_BASE << shift;
    assign tick     = (r.tick_cnt == half_lim - 16'h0001);

    // Line events from the synchronised copies only
    assign scl_rise  = scl_s & ~r.scl_d;
    assign scl_fall  = ~scl_s & r.scl_d;
    assign start_det = ~sda_s & r.sda_d & scl_s & r.scl_d;
    assign stop_det  = sda_s & ~r.sda_d & scl_s & r.scl_d;

    assign scl_o        = 1'b0;
    assign sda_o        = 1'b0;
    assign scl_oe       = r.scl_drv;
    assign sda_oe       = r.sda_drv | r.s_sda_drv;
    assign irq          = r.bus_interrupt_flag & r.bus_interrupt_enable;
    assign avs_readdata = r.rdata;

    // Register file, master sequencer and slave listener
    always_comb begin
        n         = r;
        start_req = 1'b0;
        stop_req  = 1'b0;
        n.scl_d   = scl_s;
        n.sda_d   = sda_s;
        n.bus_ack = (avs_read | avs_write) & ~r.bus_ack;
        n.lo_len  = (r.m_state == TW_M_BLO) ? r.lo_len + 16'h0001 : 16'h0000;
        // Read mux, captured as the answer is given
        if (avs_read & ~r.bus_ack) begin
            case (avs_address)
                `TW_OFS_MODE: n.rdata = {28'h0, r.msb_lsb_order, r.cks};
                `TW_OFS_CTRL: n.rdata = {24'h0, r.interface_enable, r.bus_interrupt_enable, r.master_select, r.direction_transmit, 1'b0, r.busy, r.bus_interrupt_flag, 1'b1};
                `TW_OFS_STAT: n.rdata = {24'h0, r.error_stop_flag, r.stop, r.transfer_end_flag, 1'b0, r.al, r.own_address_matched, r.general_call_seen, r.ack_bit_value};
                `TW_OFS_DATA: n.rdata = {24'h0, r.rx_data};
                `TW_OFS_RATE: n.rdata = {24'h0, `TW_RATE_RSVD, r.unit_rst, r.rate_ext};
                `TW_OFS_SADR: n.rdata = {24'h0, r.own_addr, r.fs};
                default:      n.rdata = 32'h0000_0000;
            endcase
        end
        // Reading received data in receive mode clears match flags
        if (rd && avs_address == `TW_OFS_DATA && !r.direction_transmit) begin
            n.own_address_matched = 1'b0;
            n.general_call_seen = 1'b0;
        end
        // Software writes first, so hardware sets below win
        if (wr) begin
            case (avs_address)
                `TW_OFS_MODE: begin
                    n.msb_lsb_order = wd[`TW_MODE_MLS];
                    n.cks = wd[2:0];
                end
                `TW_OFS_CTRL: begin
                    n.interface_enable  = wd[`TW_CTRL_ICE];
                    n.bus_interrupt_enable = wd[`TW_CTRL_BUS_INTERRUPT_ENABLE];
                    n.master_select  = wd[`TW_CTRL_MST];
                    n.direction_transmit  = wd[`TW_CTRL_TRS];
                    if (!wd[`TW_CTRL_BUS_INTERRUPT_FLAG]) begin
                        n.bus_interrupt_flag = 1'b0;
                    end
                    start_req = wd[`TW_CTRL_BUS_BUSY_FLAG] & ~wd[`TW_CTRL_SCP];
                    stop_req  = ~wd[`TW_CTRL_BUS_BUSY_FLAG] & ~wd[`TW_CTRL_SCP];
                end
                `TW_OFS_STAT: begin
                    n.error_stop_flag = r.error_stop_flag & wd[`TW_STAT_ERROR_STOP_FLAG];
                    n.stop = r.stop & wd[`TW_STAT_STOP];
                    n.transfer_end_flag = r.transfer_end_flag & wd[`TW_STAT_TRANSFER_END_FLAG];
                    n.al   = r.al & wd[`TW_STAT_AL];
                    n.own_address_matched  = r.own_address_matched & wd[`TW_STAT_AAS];
                    n.general_call_seen  = r.general_call_seen & wd[`TW_STAT_ADZ];
                    n.ack_bit_value = wd[`TW_STAT_ACK_BIT_VALUE];
                end
                `TW_OFS_DATA: begin
                    n.tx_data = wd;
                    n.tx_pend = 1'b1;
                    n.transfer_end_flag    = 1'b0;
                    n.own_address_matched     = 1'b0;
                    n.general_call_seen     = 1'b0;
                end
                `TW_OFS_RATE: begin
                    n.unit_rst = wd[`TW_RATE_RST];
                    n.rate_ext = wd[`TW_RATE_RATE_EXTEND_SELECT];
                end
                `TW_OFS_SADR: begin
                    n.own_addr = wd[7:1];
                    n.fs       = wd[0];
                end
                default: ;
            endcase
        end
        // Bit timer; a slave holding the clock low stretches the high phase
        if (!(r.m_state == TW_M_IDLE || r.m_state == TW_M_HOLD) && (r.scl_drv || scl_s)) begin
            n.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;
        end
        unique case (r.m_state)
            TW_M_IDLE: begin
                n.scl_drv  = 1'b0;
                n.sda_drv  = 1'b0;
                n.tick_cnt = 16'h0000;
                if (start_req && r.interface_enable && r.master_select && r.direction_transmit && !r.busy) begin
                    n.m_state = TW_M_START;
                    n.sda_drv = 1'b1;
                    n.busy    = 1'b1;
                end
            end
            TW_M_START: begin
                if (tick) begin
                    n.m_state = TW_M_HOLD;
                    n.scl_drv = 1'b1;
                    n.bus_interrupt_flag    = 1'b1;
                    n.transfer_end_flag    = 1'b1;
                end
            end
            TW_M_HOLD: begin
                n.scl_drv  = 1'b1;
                n.sda_drv  = 1'b1;
                n.tick_cnt = 16'h0000;
                if (r.tx_pend) begin
                    // address byte goes out as written, order per mls
                    n.m_state = TW_M_BLO;
                    n.tx_pend = 1'b0;
                    n.m_cnt   = 4'h0;
                    n.m_shift = r.msb_lsb_order ? tx_rev : r.tx_data;
                    n.sda_drv = ~n.m_shift[7];
                end else if (stop_req) begin
                    n.m_state = TW_M_SLO;
                end
            end
            TW_M_BLO: begin
                if (tick) begin
                    n.m_state = TW_M_BHI;
                    n.scl_drv = 1'b0;
                end
            end
            TW_M_BHI: begin
                if (tick) begin
                    if (!r.sda_drv && !sda_s) begin
                        // Another master pulled data low
                        n.m_state = TW_M_IDLE;
                        n.al      = 1'b1;
                        n.master_select     = 1'b0;
                        n.direction_transmit     = 1'b0;
                        n.sda_drv = 1'b0;
                    end else if (r.m_cnt == `TW_FRAME_LAST) begin
                        n.m_state = TW_M_ALO;
                        n.scl_drv = 1'b1;
                        n.sda_drv = 1'b0;
                    end else begin
                        n.m_state = TW_M_BLO;
                        n.scl_drv = 1'b1;
                        n.m_cnt   = r.m_cnt + 4'h1;
                        n.m_shift = {r.m_shift[6:0], 1'b0};
                        n.sda_drv = ~r.m_shift[6];
                    end
                end
            end
            TW_M_ALO: begin
                if (tick) begin
                    n.m_state = TW_M_AHI;
                    n.scl_drv = 1'b0;
                    n.bus_interrupt_flag    = 1'b1;
                    n.transfer_end_flag    = 1'b1;
                end
            end
            TW_M_AHI: begin
                if (tick) begin
                    n.ack_bit_value    = sda_s;
                    n.m_state = TW_M_HOLD;
                    n.scl_drv = 1'b1;
                    n.sda_drv = 1'b1;
                end
            end
            TW_M_SLO: begin
                if (tick) begin
                    n.m_state = TW_M_SHI;
                    n.scl_drv = 1'b0;
                end
            end
            TW_M_SHI: begin
                if (tick) begin
                    n.m_state = TW_M_SREL;
                    n.sda_drv = 1'b0;
                end
            end
            TW_M_SREL: begin
                if (tick) begin
                    n.m_state = TW_M_IDLE;
                    n.busy    = 1'b0;
                end
            end
            default: begin
                n.m_state = TW_M_IDLE;
                n.scl_drv = 1'b0;
                n.sda_drv = 1'b0;
            end
        endcase
        // Slave listener runs only while this end is not mastering
        if (r.m_state == TW_M_IDLE && r.interface_enable) begin
            if (start_det) begin
                n.busy      = 1'b1;
                n.s_state   = TW_S_SHIFT;
                n.s_addr    = 1'b1;
                n.s_cnt     = 4'h0;
                n.s_sda_drv = 1'b0;
            end else if (stop_det) begin
                n.busy      = 1'b0;
                n.stop      = 1'b1;
                n.error_stop_flag      = r.error_stop_flag | (r.s_state == TW_S_SHIFT && r.s_cnt != 4'h0);
                n.s_state   = TW_S_IDLE;
                n.s_sda_drv = 1'b0;
            end else begin
                unique case (r.s_state)
                    TW_S_IDLE, TW_S_SKIP: ;
                    TW_S_SHIFT: begin
                        if (scl_rise && r.s_cnt != `TW_SLV_BITS) begin
                            n.s_shift = {r.s_shift[6:0], sda_s};
                            n.s_cnt   = r.s_cnt + 4'h1;
                        end else if (scl_fall && r.s_cnt == `TW_SLV_BITS) begin
                            if (!r.s_addr) begin
                                n.rx_data   = r.s_shift;
                                n.s_sda_drv = ~r.ack_bit_value;
                                n.s_state   = TW_S_ACK;
                            end else if (r.s_shift[7:1] == `TW_GC_ADDR
                                         || (r.s_shift[7:1] == r.own_addr && !r.fs)) begin
                                n.own_address_matched       = 1'b1;
                                n.general_call_seen       = (r.s_shift[7:1] == `TW_GC_ADDR);
                                n.master_select       = 1'b0;
                                n.direction_transmit       = 1'b0;
                                n.s_sda_drv = ~r.s_shift[0];
                                n.s_state   = TW_S_ACK;
                            end else begin
                                n.s_state = TW_S_SKIP;
                            end
                        end
                    end
                    TW_S_ACK: begin
                        if (scl_rise) begin
                            // no transfer end in slave mode
                            n.bus_interrupt_flag = 1'b1;
                        end else if (scl_fall) begin
                            n.s_sda_drv = 1'b0;
                            n.s_cnt     = 4'h0;
                            n.s_addr    = 1'b0;
                            n.s_state   = TW_S_SHIFT;
                        end
                    end
                endcase
            end
        end
        if (r.unit_rst) begin
            n.m_state   = TW_M_IDLE;
            n.s_state   = TW_S_IDLE;
            n.scl_drv   = 1'b0;
            n.sda_drv   = 1'b0;
            n.s_sda_drv = 1'b0;
            n.tx_pend   = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r          <= '0;
            r.own_addr <= `TW_RST_ADDR;
            r.fs       <= `TW_RST_FS;
            r.scl_d    <= 1'b1;
            r.sda_d    <= 1'b1;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence seq_start_done;
        $past(r.m_state) == TW_M_START && r.m_state == TW_M_HOLD;
    endsequence

    sequence seq_ninth_rise;
        r.m_state == TW_M_ALO ##1 r.m_state == TW_M_AHI;
    endsequence

    chk_rsvd_read_one: assert property (
        (avs_read && !avs_waitrequest && avs_address == `TW_OFS_RATE) |-> ##1 avs_readdata[7:2] == 6'h3F
    ) else $error("reserved rate bits not one");
    chk_unit_rst_idle: assert property (
        (r.unit_rst && r.m_state != TW_M_IDLE) |=> r.m_state == TW_M_IDLE && !scl_oe && $stable(r.own_addr)
    ) else $error("unit reset did not idle engine");
    chk_low_phase_len: assert property (
        ($past(r.m_state) == TW_M_BLO && r.m_state == TW_M_BHI) |-> r.lo_len == half_lim
    ) else $error("clock low phase length wrong");
    chk_frame_eight_bits: assert property (
        ($past(r.m_state) == TW_M_BHI && r.m_state == TW_M_ALO) |-> $past(r.m_cnt) == 4'h7
    ) else $error("frame not eight bits");
    chk_start_cond: assert property (
        ($past(r.m_state) == TW_M_IDLE && r.m_state == TW_M_START) |-> sda_oe && !scl_oe ##1 sda_oe && !scl_oe
    ) else $error("start condition malformed");
    chk_stop_cond: assert property (
        ($past(r.m_state) == TW_M_SHI && r.m_state == TW_M_SREL) |-> !sda_oe && !scl_oe && $past(sda_oe)
    ) else $error("stop condition malformed");
    chk_start_flags: assert property (
        seq_start_done |-> r.bus_interrupt_flag && r.transfer_end_flag && r.busy
    ) else $error("start flags not set");
    chk_ninth_flag_hold: assert property (
        seq_ninth_rise |-> r.bus_interrupt_flag && r.transfer_end_flag && !scl_oe
    ) else $error("ninth rise flag missing");
    chk_frame_end_state: assert property (
        seq_ninth_rise |-> r.busy && r.master_select
    ) else $error("frame end state wrong");
    chk_own_match_state: assert property (
        $rose(r.own_address_matched) |-> !r.master_select && !r.direction_transmit && r.busy
    ) else $error("own match state wrong");
    chk_gc_flags: assert property (
        $rose(r.general_call_seen) |-> r.own_address_matched && r.busy && !r.master_select
    ) else $error("general call flags wrong");
    chk_slave_no_transfer_end_flag: assert property (
        (r.s_state == TW_S_ACK && r.m_state == TW_M_IDLE) |=> !$rose(r.transfer_end_flag)
    ) else $error("transfer end set by slave");
    chk_first_bit_order: assert property (
        (r.m_state == TW_M_HOLD && r.tx_pend && !r.unit_rst)
        |=> sda_oe == !($past(r.msb_lsb_order) ? $past(r.tx_data[0]) : $past(r.tx_data[7]))
    ) else $error("first data bit wrong");
    chk_idle_released: assert property (
        (r.m_state == TW_M_IDLE && r.s_state == TW_S_IDLE) |-> !scl_oe && !sda_oe
    ) else $error("lines driven while idle");

endmodule

`default_nettype wire

// ### logic/tw_sync.sv
/*
 * Two flip-flop synchroniser for one bus line.
 * Assumes the line idles high, so both stages reset to one.
 */
`default_nettype none

module tw_sync
    import tw_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic d,
    output logic      q
);

    tw_sync_t r;
    tw_sync_t n;

    // First stage feeds only the second
    always_comb begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= 2'h3;
        end else begin
            r <= n;
        end
    end

    assign q = r.s2;

endmodule

`default_nettype wire

// ### pkg/tw_cfg.svh
/*
 * Register offsets, field positions, reset values and timing
 * counts of the two-wire master interface.
 * Assumes a byte-addressed Avalon-MM slave with 32-bit data.
 */
`ifndef TW_CFG_SVH
`define TW_CFG_SVH

// Byte offsets, one aligned word per register
`define TW_OFS_MODE   5'h00
`define TW_OFS_CTRL   5'h04
`define TW_OFS_STAT   5'h08
`define TW_OFS_DATA   5'h0C
`define TW_OFS_RATE   5'h10
`define TW_OFS_SADR   5'h14

// Mode register fields
`define TW_MODE_MLS   3

// Control register fields
`define TW_CTRL_ICE   7
`define TW_CTRL_BUS_INTERRUPT_ENABLE  6
`define TW_CTRL_MST   5
`define TW_CTRL_TRS   4
`define TW_CTRL_BUS_BUSY_FLAG  2
`define TW_CTRL_BUS_INTERRUPT_FLAG  1
`define TW_CTRL_SCP   0

// Status register fields
`define TW_STAT_ERROR_STOP_FLAG  7
`define TW_STAT_STOP  6
`define TW_STAT_TRANSFER_END_FLAG  5
`define TW_STAT_AL    3
`define TW_STAT_AAS   2
`define TW_STAT_ADZ   1
`define TW_STAT_ACK_BIT_VALUE  0

// Unit reset and rate register fields
`define TW_RATE_RST   1
`define TW_RATE_RATE_EXTEND_SELECT  0
`define TW_RATE_RSVD  6'h3F

// Reset values
`define TW_RST_ADDR   7'h00
`define TW_RST_FS     1'b1

// Timing: half bit period in clk cycles before prescale shift
`define TW_HALF_BASE  16'h0004
`define TW_FRAME_LAST 4'h7
`define TW_SLV_BITS   4'h8
`define TW_GC_ADDR    7'h00

`endif

// ### pkg/tw_pkg.sv
/*
 * Types of the two-wire master interface: state encodings and
 * the packed state records of the design modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package tw_pkg;

    // Master sequencer, Gray coded along start, byte, ack, stop
    typedef enum logic [3:0] {
        TW_M_IDLE  = 4'h0,
        TW_M_START = 4'h1,
        TW_M_HOLD  = 4'h3,
        TW_M_BLO   = 4'h2,
        TW_M_BHI   = 4'h6,
        TW_M_ALO   = 4'h7,
        TW_M_AHI   = 4'h5,
        TW_M_SLO   = 4'h4,
        TW_M_SHI   = 4'hC,
        TW_M_SREL  = 4'hD
    } tw_mstate_t;

    // Slave listener
    typedef enum logic [1:0] {
        TW_S_IDLE  = 2'h0,
        TW_S_SHIFT = 2'h1,
        TW_S_ACK   = 2'h3,
        TW_S_SKIP  = 2'h2
    } tw_sstate_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } tw_sync_t;

    typedef struct packed {
        logic        msb_lsb_order;
        logic [2:0]  cks;
        logic        interface_enable;
        logic        bus_interrupt_enable;
        logic        master_select;
        logic        direction_transmit;
        logic        bus_interrupt_flag;
        logic        busy;
        logic        error_stop_flag;
        logic        stop;
        logic        transfer_end_flag;
        logic        al;
        logic        own_address_matched;
        logic        general_call_seen;
        logic        ack_bit_value;
        logic        unit_rst;
        logic        rate_ext;
        logic [6:0]  own_addr;
        logic        fs;
        logic [7:0]  tx_data;
        logic        tx_pend;
        logic [7:0]  rx_data;
        tw_mstate_t  m_state;
        logic [3:0]  m_cnt;
        logic [7:0]  m_shift;
        logic [15:0] tick_cnt;
        logic [15:0] lo_len;
        tw_sstate_t  s_state;
        logic        s_addr;
        logic [3:0]  s_cnt;
        logic [7:0]  s_shift;
        logic        scl_drv;
        logic        sda_drv;
        logic        s_sda_drv;
        logic        scl_d;
        logic        sda_d;
        logic        bus_ack;
        logic [31:0] rdata;
    } tw_state_t;

endpackage

`default_nettype wire

// ### testbench/tw_slave_model.sv
/*
 * Behavioural slave on the two-wire bus: shifts bytes in MSB first, acks on command.
 * Assumes lines already resolved with pull-ups; no clock stretching.
 */
`default_nettype none

module tw_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    output logic            sda_oe,
    output logic [7:0]      rx
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    initial sda_oe = 1'h0;
    // start restarts the bit count; short wait lets a clock fall in the same step settle
    always @(negedge sda) begin
        #1;
        if (scl === 1'h1) n = 0;
    end
    // eight bits, then the ack clock
    always @(posedge scl) begin
        if (n < 8) rx = {rx[6:0], sda};
        n = n + 1;
    end
    // pull data low in the ack slot only
    always @(negedge scl) begin
        sda_oe = (n == 8) && ack_en;
        if (n == 9) n = 0;
    end
endmodule

`default_nettype wire

// ### testbench/two_wire_master_transmit_test.sv
/*
 * Bench: two master transmit transfers of two frames each, rate and unit reset registers.
 * Assumes pull-ups on both lines and one wait state per access.
 */
`default_nettype none
`include "tw_cfg.svh"

module two_wire_master_transmit_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0, rst_b = 1'h0, avs_read = 1'h0, avs_write = 1'h0, ack_en = 1'h1;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic        avs_waitrequest, scl_oe, sda_oe, s_oe, irq;
    logic [3:0]  be = 4'hF;
    logic [7:0]  rx, q, a, d;
    int          n_errors = 0, tests_run = 0, cyc = 0, starts = 0, stops = 0;
    wire logic   scl = ~scl_oe;
    wire logic   sda = ~(sda_oe | s_oe);
    always #50 clk = ~clk;
    tw_master i_tw_master (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(be), .avs_readdata, .avs_waitrequest, .scl_i(scl), .scl_o(), .scl_oe,
        .sda_i(sda), .sda_o(), .sda_oe, .irq);
    tw_slave_model i_tw_slave_model (.scl, .sda, .ack_en, .sda_oe(s_oe), .rx);
    // Data edges with clock high are starts or stops; short wait lets a clock fall in the same step settle
    always @(sda) begin
        #1;
        if (scl === 1'h1 && rst_b) begin
            if (sda) stops++;
            else starts++;
        end
    end
    // Hang guard, far above four short frames
    always @(posedge clk) if (++cyc == 40000) begin
        n_errors++;
        results();
    end
    task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] wd);
        @(posedge clk);
        {avs_read, avs_write, avs_address, avs_writedata} <= {~w, w, ad, 24'h0, wd};
        do @(posedge clk); while (avs_waitrequest !== 1'h0);
        q = avs_readdata[7:0];
        {avs_read, avs_write} <= 2'h0;
    endtask
    task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", s, exp, seen);
        end
    endtask
    // Poll control until a flag takes a value
    task automatic wflag(input int b, input logic v);
        do bus(1'h0, `TW_OFS_CTRL, 8'h00); while (q[b] !== v);
    endtask
    // Frame flag, then the ack high phase must end before the ack bit is read
    task automatic whold;
        wflag(1, 1'h1);
        while (scl !== 1'h0) @(posedge clk);
        repeat (40) @(posedge clk);
    endtask
    function automatic logic [7:0] rev(logic [7:0] x, logic m);
        logic [7:0] y;
        y = {<<{x}};
        return m ? y : x;
    endfunction
    task automatic results;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hC80A));
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        bus(1'h1, `TW_OFS_RATE, 8'h01);
        bus(1'h0, `TW_OFS_RATE, 8'h00);
        chk("rate", q, 8'hFD);
        $display("test rate done");
        // Pass 1 flips bit order and rate, so the bit time stays the same
        for (int i = 0; i < 2; i++) begin
            a = {7'(($urandom % 126) + 1), 1'h0};
            d = 8'($urandom);
            ack_en = 1'h1;
            bus(1'h1, `TW_OFS_RATE, {7'h00, i[0]});
            bus(1'h1, `TW_OFS_MODE, {4'h0, i[0], 3'(i)});
            bus(1'h1, `TW_OFS_CTRL, 8'hF0);
            wflag(2, 1'h0);
            bus(1'h1, `TW_OFS_CTRL, 8'hF4);
            wflag(1, 1'h1);
            chk("irq", {7'h00, irq}, 8'h01);
            bus(1'h0, `TW_OFS_STAT, 8'h00);
            chk("start", q, 8'h20);
            bus(1'h1, `TW_OFS_DATA, a);
            bus(1'h1, `TW_OFS_CTRL, 8'hF4);
            whold();
            chk("ctrl", q, 8'hF7);
            chk("hold", {7'h00, scl}, 8'h00);
            bus(1'h0, `TW_OFS_STAT, 8'h00);
            chk("ack", q, 8'h20);
            chk("addr", rx, rev(a, i[0]));
            ack_en = 1'h0;
            bus(1'h1, `TW_OFS_DATA, d);
            bus(1'h1, `TW_OFS_CTRL, 8'hF4);
            whold();
            bus(1'h0, `TW_OFS_STAT, 8'h00);
            chk("nack", q, 8'h21);
            chk("data", rx, rev(d, i[0]));
            bus(1'h1, `TW_OFS_CTRL, 8'hF0);
            wflag(2, 1'h0);
            bus(1'h1, `TW_OFS_STAT, 8'h00);
            bus(1'h0, `TW_OFS_STAT, 8'h00);
            chk("idle", q, 8'h00);
            chk("lines", {6'h00, scl, sda}, 8'h03);
            $display("test xfer %0d done", i);
        end
        chk("starts", 8'(starts), 8'h02);
        chk("stops", 8'(stops), 8'h02);
        bus(1'h1, `TW_OFS_RATE, 8'h02);
        bus(1'h0, `TW_OFS_CTRL, 8'h00);
        chk("keep", q, 8'hF1);
        bus(1'h0, `TW_OFS_RATE, 8'h00);
        chk("rst bit", q, 8'hFE);
        bus(1'h1, `TW_OFS_RATE, 8'h00);
        be <= 4'hE;
        bus(1'h1, `TW_OFS_RATE, 8'h03);
        be <= 4'hF;
        bus(1'h0, `TW_OFS_RATE, 8'h00);
        chk("byte enable", q, 8'hFC);
        bus(1'h0, 5'h1C, 8'h00);
        chk("unmapped", q, 8'h00);
        $display("test regs done");
        results();
    end
endmodule

`default_nettype wire
